// *** src/sbsp_fifo.sv ***
// Small FIFO in flip-flops with valid and ready on both sides.
// Assumes one clock; full and empty are exact.
`timescale 1ns/100ps
module sbsp_fifo #(
	parameter int WIDTH = 8,
	parameter int DEPTH = 16
)(
	input wire logic clk_sys, // System clock
	input wire logic reset, // Async reset, high
	input wire logic [WIDTH-1:0] in_data, // Fill data
	input wire logic in_valid, // Fill valid
	output logic in_ready, // Not full
	output logic [WIDTH-1:0] out_data, // Head word
	output logic out_valid, // Not empty
	input wire logic out_ready // Drain accepts
);
	localparam int PW = $clog2(DEPTH);
	typedef struct packed
	{
		logic [DEPTH-1:0][WIDTH-1:0] mem;
		logic [PW-1:0] wp;
		logic [PW-1:0] rp;
		logic [PW:0] cnt;
	} sbsp_fifo_s;
	sbsp_fifo_s st;
	sbsp_fifo_s next_st;
	logic push;
	logic pop;

	// Pointer and count update
	always_comb
	begin
		next_st = st;
		push = in_valid && (st.cnt != (PW+1)'(DEPTH));
		pop = out_ready && (st.cnt != '0);
		if (push)
		begin
			next_st.mem[st.wp] = in_data;
			next_st.wp = st.wp + 1'b1;
		end
		if (pop)
			next_st.rp = st.rp + 1'b1;
		if (push && !pop)
			next_st.cnt = st.cnt + 1'b1;
		else if (pop && !push)
			next_st.cnt = st.cnt - 1'b1;
	end

	always_ff @(posedge clk_sys or posedge reset)
	begin
		if (reset)
			st <= '0;
		else
			st <= next_st;
	end

	assign in_ready = (st.cnt != (PW+1)'(DEPTH));
	assign out_valid = (st.cnt != '0);
	assign out_data = st.mem[st.rp];
endmodule

// *** src/sbsp_pkg.sv ***
// Constants shared by the burst memory port.
// Assumes a single 200 MHz system clock and an active-high async reset.
package sbsp_pkg;
	localparam int SBSP_ADDR_W = 10;
	localparam int SBSP_LANES = 2;
	localparam int SBSP_LANE_W = 9;
	localparam int SBSP_FIFO_DEPTH = 16;
	localparam logic [1:0] SBSP_BURST_ONE = 2'h1;
	localparam logic [1:0] SBSP_RST_BURST = 2'h0;
	localparam logic SBSP_RST_MODE = 1'b1;
	localparam logic SBSP_RST_SELECTED = 1'b0;
endpackage

// *** src/sbsp_port.sv ***
// Synchronous flow-through burst memory, pin-level port and core array.
// Assumes all synchronous pins are already timed to clk_sys; the bench
// resolves the two-way data wires from the drive enable, data_oe.
`timescale 1ns/100ps
// Overview of operation
// - All synchronous inputs are captured only at the rising clock edge.
// - Burst counter steps on an edge with advance sampled low.
// - Selected when primary low, secondary high and tertiary low.
// - Chip enables sampled only when a strobe loads a new address.
// - Processor strobe ignored while primary chip enable is high.
// - Output enable low drives data pins; high floats them as inputs.
// - First read clock after deselect keeps outputs floating.
// - Processor strobe loads address and low two bits into counter.
// - Controller strobe loads address and low two bits into counter.
// - Both strobes low: only the processor strobe acts.
// - Sleep high freezes activity and keeps stored data.
// - Data pins feed a write data register at the rising edge.
// - Read data comes from address sampled at the preceding edge.
// - Outputs float on write data, first clock, and deselect.
// - Parity lines act as data, written per byte lane select.
// - Burst order strap low is linear, high is interleaved.
// - All-bytes write low writes every lane.
// - Lane selects write only with qualifier asserted.
// - Interleaved order XORs start bits with 01, 10, 11.
// - Linear order adds one modulo four.
module sbsp_port #(
	parameter int ADDR_W = sbsp_pkg::SBSP_ADDR_W,
	parameter int LANES = sbsp_pkg::SBSP_LANES,
	parameter int LANE_W = sbsp_pkg::SBSP_LANE_W,
	parameter int FIFO_DEPTH = sbsp_pkg::SBSP_FIFO_DEPTH
)(
	input wire logic clk_sys, // System clock
	input wire logic reset, // Async reset, high
	input wire logic [ADDR_W-1:0] addr, // Address pins
	input wire logic select_low_primary, // Chip enable, low active
	input wire logic select_high_secondary, // Chip enable, high active
	input wire logic select_low_tertiary, // Chip enable, low active
	input wire logic processor_addr_strobe_n, // Processor strobe
	input wire logic controller_addr_strobe_n, // Controller strobe
	input wire logic burst_advance_n, // Advance, low active
	input wire logic byte_write_qualifier_n, // Lane write qualifier
	input wire logic [LANES-1:0] byte_lane_write_select_n, // Lane selects
	input wire logic all_bytes_write_n, // Global write
	input wire logic output_enable_n, // Output enable
	input wire logic sleep_request, // Sleep, high active
	input wire logic burst_order_mode, // 1 interleaved, 0 linear
	input wire logic [LANES*(LANE_W-1)-1:0] data_in, // Data pins in
	input wire logic [LANES-1:0] parity_lines_in, // Parity pins in
	output logic [LANES*(LANE_W-1)-1:0] data_out, // Data pins out
	output logic [LANES-1:0] parity_lines_out, // Parity pins out
	output logic data_oe, // Drive enable, data and parity
	output logic wr_ready // Write path can accept
);
	import sbsp_pkg::*;

	localparam int WORD_W = LANES*LANE_W;
	localparam int DEPTH = 1 << ADDR_W;
	localparam int FW = ADDR_W + LANES + WORD_W;

	typedef enum logic [1:0]
	{
		SBSP_IDLE = 2'b00,
		SBSP_FIRST = 2'b01,
		SBSP_ACTIVE = 2'b10
	} sbsp_phase_e;

	typedef struct packed
	{
		logic [DEPTH-1:0][WORD_W-1:0] mem;
		logic [ADDR_W-1:0] base;
		logic [1:0] start;
		logic [1:0] burst;
		sbsp_phase_e phase;
		logic proc_pending;
		logic mode;
		logic [WORD_W-1:0] rd;
		logic oe;
		logic rdy;
	} sbsp_state_s;

	sbsp_state_s st;
	sbsp_state_s next_st;

	logic proc_go;
	logic ctrl_go;
	logic sel;
	logic [LANES-1:0] lane_we;
	logic wr_req;
	logic [ADDR_W-1:0] cur_addr;
	logic [ADDR_W-1:0] ld_addr;
	logic [WORD_W-1:0] pin_word;
	logic [FW-1:0] f_in;
	logic [FW-1:0] f_out;
	logic f_in_ready;
	logic f_out_valid;
	logic f_out_ready;
	logic [WORD_W-1:0] merged;
	logic [ADDR_W-1:0] f_addr;
	logic [LANES-1:0] f_we;
	logic [WORD_W-1:0] f_data;

	// Recombine data and parity pins into one word per lane
	always_comb
	begin
		for (int i = 0; i < LANES; i++)
		begin
			pin_word[i*LANE_W +: LANE_W] = {parity_lines_in[i],
				data_in[i*(LANE_W-1) +: LANE_W-1]};
		end
	end

	// Strobe qualification; processor strobe wins
	assign proc_go = !processor_addr_strobe_n && !select_low_primary;
	assign ctrl_go = !controller_addr_strobe_n && !proc_go
		&& processor_addr_strobe_n;
	assign sel = !select_low_primary && select_high_secondary
		&& !select_low_tertiary;

	// Lane write enables
	always_comb
	begin
		if (!all_bytes_write_n)
			lane_we = '1;
		else if (!byte_write_qualifier_n)
			lane_we = ~byte_lane_write_select_n;
		else
			lane_we = '0;
	end
	assign wr_req = |lane_we;

	// Writes land where this edge leaves the address, so a controller
	// strobe write goes to the location it loads, not the previous one
	assign cur_addr = {next_st.base[ADDR_W-1:2], next_st.burst};
	assign ld_addr = {addr[ADDR_W-1:2], addr[1:0]};

	// Writes are queued so the array update is decoupled from the pins
	assign f_in = {lane_we, cur_addr, pin_word};
	assign f_addr = f_out[FW-LANES-1 -: ADDR_W];
	assign f_we = f_out[FW-1 -: LANES];
	assign f_data = f_out[WORD_W-1:0];
	assign f_out_ready = !sleep_request;

	always_comb
	begin
		merged = st.mem[f_addr];
		for (int i = 0; i < LANES; i++)
		begin
			if (f_we[i])
				merged[i*LANE_W +: LANE_W] = f_data[i*LANE_W +: LANE_W];
		end
	end

	// Main next-state logic
	always_comb
	begin
		next_st = st;
		next_st.rdy = f_in_ready;
		if (!sleep_request)
		begin
			if (f_out_valid)
				next_st.mem[f_addr] = merged;
			if (proc_go || ctrl_go)
			begin
				// Load address and burst start
				next_st.base = ld_addr;
				next_st.start = addr[1:0];
				next_st.burst = addr[1:0];
				next_st.mode = burst_order_mode;
				next_st.proc_pending = proc_go;
				if (!sel)
					next_st.phase = SBSP_IDLE;
				else if (st.phase == SBSP_IDLE)
					next_st.phase = SBSP_FIRST;
				else
					next_st.phase = SBSP_ACTIVE;
			end
			else if (!burst_advance_n && st.phase != SBSP_IDLE)
			begin
				// Step the burst counter
				// Interleaved: step the offset, then fold it onto the start
				if (st.mode)
					next_st.burst = st.start
						^ ((st.burst ^ st.start) + SBSP_BURST_ONE);
				else
					next_st.burst = st.burst + SBSP_BURST_ONE;
				next_st.phase = SBSP_ACTIVE;
				next_st.proc_pending = 1'b0;
			end
			else
			begin
				next_st.phase = (st.phase == SBSP_IDLE) ? SBSP_IDLE
					: SBSP_ACTIVE;
				next_st.proc_pending = 1'b0;
			end
			// Write data phase; processor first cycle ignores write inputs
			// Float on any detected write, even one the queue refuses
			if (wr_req && !proc_go)
				next_st.oe = 1'b0;
			else
				next_st.oe = !output_enable_n
					&& (next_st.phase == SBSP_ACTIVE);
			next_st.rd = next_st.mem[{next_st.base[ADDR_W-1:2],
				next_st.burst}];
		end
	end

	// State register, all pins captured on the rising edge
	always_ff @(posedge clk_sys or posedge reset)
	begin
		if (reset)
		begin
			st <= '0;
			st.phase <= SBSP_IDLE;
			st.mode <= SBSP_RST_MODE;
			st.burst <= SBSP_RST_BURST;
		end
		else
			st <= next_st;
	end

	sbsp_fifo #(
		.WIDTH(FW),
		.DEPTH(FIFO_DEPTH)
	) u_wr_fifo (
		.clk_sys(clk_sys),
		.reset(reset),
		.in_data(f_in),
		.in_valid(next_st.phase != SBSP_IDLE && wr_req && !proc_go
			&& !sleep_request),
		.in_ready(f_in_ready),
		.out_data(f_out),
		.out_valid(f_out_valid),
		.out_ready(f_out_ready)
	);

	// Split stored word back onto data and parity pins
	always_comb
	begin
		for (int i = 0; i < LANES; i++)
		begin
			data_out[i*(LANE_W-1) +: LANE_W-1] =
				st.rd[i*LANE_W +: LANE_W-1];
			parity_lines_out[i] = st.rd[i*LANE_W+LANE_W-1];
		end
	end
	assign data_oe = st.oe;
	assign wr_ready = st.rdy;
endmodule

// *** verif/sbsp_master_model.sv ***
// Bus master side of the shared data wires.
// Assumes data_oe marks device drive; released wires toggle.
`timescale 1ns/100ps
module sbsp_master_model (
	input wire logic clk_sys, // Clock
	input wire logic data_oe, // Device drives
	input wire logic [15:0] data_out, // Device data
	input wire logic [1:0] parity_lines_out, // Device parity
	input wire logic drive, // Master drives
	input wire logic [17:0] wdata, // Master word
	output logic [15:0] data_in, // Wire data
	output logic [1:0] parity_lines_in // Wire parity
);
	logic [17:0] last;
	// Floating wires invert each cycle so no stale value can match
	always_comb
	begin
		if (data_oe)
			{parity_lines_in, data_in} = {parity_lines_out, data_out};
		else if (drive)
			{parity_lines_in, data_in} = wdata;
		else
			{parity_lines_in, data_in} = ~last;
	end
	always_ff @(posedge clk_sys)
		last <= {parity_lines_in, data_in};
endmodule

// *** verif/sbsp_port_chk.sv ***
// Pin checker for the burst memory port.
// Assumes it is bound into sbsp_port and sees only its ports.
`timescale 1ns/100ps
module sbsp_port_chk #(
	parameter int LANES = 2,
	parameter int LANE_W = 9
)(
	input wire logic clk_sys, // Clock
	input wire logic reset, // Reset
	input wire logic select_low_primary, // Enable
	input wire logic select_high_secondary, // Enable
	input wire logic select_low_tertiary, // Enable
	input wire logic processor_addr_strobe_n, // Strobe
	input wire logic controller_addr_strobe_n, // Strobe
	input wire logic burst_advance_n, // Advance
	input wire logic all_bytes_write_n, // Write
	input wire logic byte_write_qualifier_n, // Qualifier
	input wire logic output_enable_n, // Drive request
	input wire logic sleep_request, // Sleep
	input wire logic [LANES*(LANE_W-1)-1:0] data_out, // Data
	input wire logic data_oe // Drive enable
);
	default clocking cb @(posedge clk_sys);
	endclocking
	default disable iff (reset);
	// Load outcomes; a processor strobe with primary enable high is ignored
	wire desel = !controller_addr_strobe_n && processor_addr_strobe_n &&
		(select_low_primary || !select_high_secondary || select_low_tertiary);
	wire sel_ld = !controller_addr_strobe_n && !select_low_primary &&
		select_high_secondary && !select_low_tertiary;
	wire ign = !processor_addr_strobe_n && select_low_primary &&
		controller_addr_strobe_n;
	wire hold = processor_addr_strobe_n && controller_addr_strobe_n &&
		burst_advance_n && all_bytes_write_n && byte_write_qualifier_n;
	property p_oe_cause; $rose(data_oe) |-> !$past(output_enable_n); endproperty
	a_oe_cause: assert property (p_oe_cause) else $error("oe cause");
	property p_oe_off; output_enable_n |=> !data_oe; endproperty
	a_oe_off: assert property (p_oe_off) else $error("oe off");
	property p_desel; desel |=> !data_oe; endproperty
	a_desel: assert property (p_desel) else $error("desel");
	property p_ign; desel ##1 ign |=> !data_oe; endproperty
	a_ign: assert property (p_ign) else $error("strobe ign");
	property p_first; desel ##1 sel_ld |=> !data_oe; endproperty
	a_first: assert property (p_first) else $error("first clk");
	property p_sleep; sleep_request |=> $stable(data_out) && $stable(data_oe);
	endproperty
	a_sleep: assert property (p_sleep) else $error("sleep");
	property p_wr; !all_bytes_write_n && processor_addr_strobe_n |=> !data_oe;
	endproperty
	a_wr: assert property (p_wr) else $error("wr float");
	property p_hold; hold && data_oe && !output_enable_n |=> $stable(data_out);
	endproperty
	a_hold: assert property (p_hold) else $error("hold");
endmodule
bind sbsp_port sbsp_port_chk #(.LANES(LANES), .LANE_W(LANE_W)) sbsp_port_chk_i (.*);

// *** verif/test_sync_burst_sram_port.sv ***
// Bench: word and lane writes, then bursts in both orders.
// Assumes 200 MHz; inputs change on the falling edge.
`timescale 1ns/100ps
module test_sync_burst_sram_port;
	import sbsp_pkg::*;
	logic clk_sys = 1'h0, reset = 1'h1, drive = 1'h0, data_oe, wr_ready;
	logic select_low_primary = 1'h1, select_high_secondary = 1'h1;
	logic select_low_tertiary = 1'h0, processor_addr_strobe_n = 1'h1;
	logic controller_addr_strobe_n = 1'h1, burst_advance_n = 1'h1;
	logic byte_write_qualifier_n = 1'h1, all_bytes_write_n = 1'h1;
	logic output_enable_n = 1'h1, sleep_request = 1'h0;
	logic burst_order_mode = 1'h1;
	logic [1:0] byte_lane_write_select_n = 2'h3;
	logic [1:0] parity_lines_in, parity_lines_out;
	logic [9:0] addr = 10'h000;
	logic [15:0] data_in, data_out;
	logic [17:0] wdata = 18'h00000, m [4];
	int n_errors = 0, tests_run = 0;
	wire [17:0] rdw = {parity_lines_out, data_out};
	// Device and the master sharing its wires
	sbsp_port sbsp_port_i (.*);
	sbsp_master_model sbsp_master_model_i (.*);
	// 5 ns period
	always #2.5 clk_sys = ~clk_sys;
	task automatic chk(string n, logic [17:0] e, g);
		tests_run++;
		if (e !== g)
		begin
			n_errors++;
			$display("mismatch %s expected %h seen %h", n, e, g);
		end
	endtask
	task automatic test_done();
		$display("checks %0d errors %0d", tests_run, n_errors);
		if (n_errors == 0 && tests_run > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask
	// One cycle: set at a falling edge, return at the next one
	task automatic bus(logic p, logic c, logic v, logic [9:0] a);
		processor_addr_strobe_n = p;
		controller_addr_strobe_n = c;
		burst_advance_n = v;
		addr = a;
		@(negedge clk_sys);
	endtask
	// Controller-strobe write; controls stay up for back-to-back use
	task automatic wr(logic [9:0] a, logic g, q, logic [1:0] s, logic [17:0] d);
		int i;
		for (i = 0; i < 20 && wr_ready !== 1'h1; i++)
			@(negedge clk_sys);
		if (i == 20)
		begin
			n_errors++;
			test_done();
		end
		{select_low_primary, output_enable_n, drive} = 3'h3;
		all_bytes_write_n = g;
		byte_write_qualifier_n = q;
		byte_lane_write_select_n = s;
		wdata = d;
		bus(1'h1, 1'h0, 1'h1, a);
		for (i = 0; i < 2; i++)
			if (!g || (!q && !s[i]))
				{m[a[1:0]][16+i], m[a[1:0]][8*i+:8]} = {d[16+i], d[8*i+:8]};
	endtask
	// Drop the write controls and let the write queue drain
	task automatic rest();
		{all_bytes_write_n, byte_write_qualifier_n, drive} = 3'h6;
		byte_lane_write_select_n = 2'h3;
		repeat (8) @(negedge clk_sys);
	endtask
	// Burst from deselect; primary enable goes off during continuation
	task automatic rd(logic mode, logic p, logic [9:0] a);
		logic [1:0] k;
		burst_order_mode = mode;
		{output_enable_n, select_high_secondary} = 2'h0;
		bus(1'h1, 1'h0, 1'h1, a);
		{select_high_secondary, select_low_primary} = 2'h3;
		bus(1'h0, 1'h1, 1'h1, a);
		select_low_tertiary = 1'h1;
		bus(1'h1, 1'h0, 1'h1, a);
		{select_low_tertiary, select_low_primary, all_bytes_write_n} = {2'h0, p};
		bus(p, 1'h0, 1'h1, a);
		chk("first_oe", 18'h0, data_oe);
		{all_bytes_write_n, select_low_primary, k} = 4'hC;
		for (int j = 0; j < 7; j++)
		begin
			sleep_request = (j == 4);
			bus(1'h1, 1'h1, j == 0 || j == 6, a);
			k = k + ((j != 0 && j != 4 && j != 6) ? 2'h1 : 2'h0);
			chk("word", m[mode ? a[1:0] ^ k : a[1:0] + k], rdw);
			chk("rd_oe", 18'h1, data_oe);
		end
		{sleep_request, output_enable_n} = 2'h1;
		bus(1'h1, 1'h1, 1'h1, a);
		chk("oe_off", 18'h0, data_oe);
	endtask
	// Fill, read interleaved, patch lanes, read linear
	initial
	begin
		repeat (4) @(negedge clk_sys);
		reset = 1'h0;
		for (int i = 0; i < 4; i++)
			wr(10'h0C4 + 10'(i), 1'h0, 1'h1, 2'h3, 18'h1A5C3 + 18'(i * 'h10101));
		rest();
		rd(1'h1, 1'h1, 10'h0C5);
		wr(10'h0C6, 1'h1, 1'h0, 2'h2, 18'h3FFFF);
		wr(10'h0C7, 1'h1, 1'h1, 2'h0, 18'h3FFFF);
		wr(10'h0C4, 1'h1, 1'h0, 2'h1, 18'h00000);
		rest();
		rd(1'h0, 1'h0, 10'h0C6);
		test_done();
	end
endmodule
